// ---- hw/remote_update_config_control.sv ----
// Page selection, user watchdog, cause recording and soft-error flag
//
// How it works
// - Remote mode power-up loads page zero first.
// - Watchdog expiry records cause, reloads factory image.
// - Watchdog forced off while factory image runs.
// - Application load failure records cause, loads factory.
// - Up to seven application pages plus factory.
// - Local mode loads its application page directly.
// - Chain enable output drives next device's input.
// - User mode checks memory with 32-bit CRC.
// - CRC mismatch raises the configuration error pin.
// - Initialise then enable I/O; tri-stated before.
// - Configuration request forces reload and reinitialise.
`timescale 1ns/100ps
`default_nettype none
`include "rupd_params.svh"

module remote_update_config_control
    import rupd_pkg::*;
#(
    parameter int unsigned WD_W = `RUPD_WD_W
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // Mode strap and device chain
    input  wire logic                   remoteMode,
    input  wire logic                   chainCfgEnableInN,
    output logic                        chainCfgEnableOutN,
    input  wire logic                   cfgRequestN,
    // Paged configuration memory
    output logic [`RUPD_PAGE_W-1:0]     pageAddr,
    output logic                        loadReq,
    input  wire logic                   loadDone,
    input  wire logic                   loadError,
    // Update control from user logic
    input  wire logic                   ctrlWrite,
    input  wire logic [`RUPD_PAGE_W-1:0] ctrlPage,
    input  wire logic                   ctrlWdEnable,
    input  wire logic [WD_W-1:0]        ctrlWdTimeout,
    input  wire logic                   appLoad,
    input  wire logic                   wdClear,
    input  wire logic                   statusRead,
    // Status
    output cause_t                      causeCode,
    output logic                        factoryActive,
    output logic                        userMode,
    output logic                        ioEnable,
    // Soft error check
    input  wire logic [7:0]             scanWord,
    input  wire logic                   scanValid,
    input  wire logic                   scanLast,
    input  wire logic [`RUPD_CRC_W-1:0] refCrc,
    output logic                        crcError
);

    localparam int unsigned TICK_CYC = `RUPD_WD_TICK_CYC;
    localparam int unsigned TICK_W   = $clog2(TICK_CYC);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

    typedef struct packed {
        cfgState_t               state;
        logic                    bootPending;
        logic                    factory;
        logic [`RUPD_PAGE_W-1:0] pageAddr;
        logic [`RUPD_PAGE_W-1:0] target;
        logic [`RUPD_PAGE_W-1:0] appPage;
        logic                    wdEn;
        logic [WD_W-1:0]         wdLimit;
        logic [WD_W-1:0]         wdCount;
        logic [TICK_W-1:0]       tick;
        cause_t                  cause;
        logic                    crcError;
        logic                    loadReq;
        logic                    ioEnable;
        logic                    chainOutN;
        logic                    userMode;
    } ctlState_t;

    ctlState_t s_r;
    ctlState_t s_nxt;
    cause_t    newCause;
    logic      leave;
    logic      wdExpire;
    logic      crcMismatch;
    logic      startLoad;

    ////////////////////////////////////////////////////////////////////////////
    // Soft error scan
    seu_crc_check crcCheck (
        .core_clk   (core_clk),
        .rst        (rst),
        .scanEnable (s_r.userMode),
        .scanWord   (scanWord),
        .scanValid  (scanValid),
        .scanLast   (scanLast),
        .refCrc     (refCrc),
        .mismatch   (crcMismatch)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    assign startLoad = (s_r.state == ST_CMD) && !chainCfgEnableInN && cfgRequestN;
    assign wdExpire  = (s_r.state == ST_USER) && s_r.wdEn && !s_r.factory && !wdClear
                       && (s_r.wdCount >= s_r.wdLimit);

    always_comb begin
        logic [`RUPD_PAGE_W-1:0] pg;
        pg       = s_r.target;
        s_nxt    = s_r;
        newCause = CAUSE_NONE;
        leave    = 1'b0;
        s_nxt.loadReq = 1'b0;
        unique case (s_r.state)
            ST_CMD: begin
                if (startLoad) begin
                    if (s_r.bootPending) begin
                        pg = remoteMode ? `RUPD_FACTORY_PAGE : `RUPD_LOCAL_PAGE;
                    end
                    s_nxt.pageAddr    = pg;
                    s_nxt.factory     = (pg == `RUPD_FACTORY_PAGE);
                    s_nxt.loadReq     = 1'b1;
                    s_nxt.bootPending = 1'b0;
                    s_nxt.state       = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (loadError) begin
                    if (!s_r.factory) begin
                        newCause = CAUSE_LOAD_ERR;
                    end
                    s_nxt.target = `RUPD_FACTORY_PAGE;
                    leave = 1'b1;
                end else if (loadDone) begin
                    s_nxt.state = ST_INIT;
                end
            end
            ST_INIT: begin
                s_nxt.ioEnable  = 1'b1;
                s_nxt.chainOutN = 1'b0;
                s_nxt.userMode  = 1'b1;
                s_nxt.wdCount   = '0;
                s_nxt.tick      = '0;
                s_nxt.state     = ST_USER;
            end
            ST_USER: begin
                if (s_r.factory || !s_r.wdEn || wdClear) begin
                    s_nxt.wdCount = '0;
                    s_nxt.tick    = '0;
                end else begin
                    s_nxt.tick = (s_r.tick == TICK_LAST) ? '0 : s_r.tick + 1'b1;
                    if (s_r.tick == TICK_LAST) begin
                        s_nxt.wdCount = s_r.wdCount + 1'b1;
                    end
                end
                if (wdExpire) begin
                    newCause     = CAUSE_WDOG;
                    s_nxt.target = `RUPD_FACTORY_PAGE;
                    leave        = 1'b1;
                end
                if (ctrlWrite && s_r.factory) begin
                    if (ctrlPage != `RUPD_FACTORY_PAGE) begin
                        s_nxt.appPage = ctrlPage;
                    end
                    s_nxt.wdEn    = ctrlWdEnable;
                    s_nxt.wdLimit = ctrlWdTimeout;
                end
                if (appLoad && s_r.factory) begin
                    s_nxt.target = s_r.appPage;
                    leave        = 1'b1;
                end
                if (crcMismatch) begin
                    s_nxt.crcError = 1'b1;
                end
            end
        endcase
        if (!cfgRequestN) begin
            newCause     = CAUSE_EXT_REQ;
            s_nxt.target = remoteMode ? `RUPD_FACTORY_PAGE : `RUPD_LOCAL_PAGE;
            leave        = 1'b1;
        end
        if (leave) begin
            s_nxt.state     = ST_CMD;
            s_nxt.ioEnable  = 1'b0;
            s_nxt.chainOutN = 1'b1;
            s_nxt.userMode  = 1'b0;
            s_nxt.crcError  = 1'b0;
            s_nxt.wdCount   = '0;
            s_nxt.tick      = '0;
        end
        if (newCause != CAUSE_NONE) begin
            s_nxt.cause = newCause;
        end else if (statusRead && s_r.factory && s_r.userMode) begin
            s_nxt.cause = CAUSE_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r <= '{state: ST_CMD, bootPending: 1'b1, factory: 1'b1,
                     pageAddr: `RUPD_FACTORY_PAGE, target: `RUPD_FACTORY_PAGE,
                     appPage: `RUPD_LOCAL_PAGE, wdEn: 1'b0, wdLimit: '0, wdCount: '0,
                     tick: '0, cause: CAUSE_NONE, crcError: 1'b0, loadReq: 1'b0,
                     ioEnable: 1'b0, chainOutN: 1'b1, userMode: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign chainCfgEnableOutN = s_r.chainOutN;
    assign pageAddr           = s_r.pageAddr;
    assign loadReq            = s_r.loadReq;
    assign causeCode          = s_r.cause;
    assign factoryActive      = s_r.factory;
    assign userMode           = s_r.userMode;
    assign ioEnable           = s_r.ioEnable;
    assign crcError           = s_r.crcError;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_boot_factory_page: assert property (
        startLoad && s_r.bootPending && remoteMode |=> loadReq && pageAddr == 3'h0 && factoryActive)
        else $error("remote boot did not load page zero");
    a_local_direct_load: assert property (
        startLoad && s_r.bootPending && !remoteMode |=> loadReq && !factoryActive
            && pageAddr == `RUPD_LOCAL_PAGE)
        else $error("local boot did not load its application page");
    a_wdog_cause_fallback: assert property (
        wdExpire && cfgRequestN |=> causeCode == CAUSE_WDOG && s_r.state == ST_CMD
            && s_r.target == 3'h0 && !ioEnable)
        else $error("watchdog expiry not recorded or no fallback");
    a_wdog_off_factory: assert property (
        factoryActive |-> s_r.wdCount == '0 && !wdExpire)
        else $error("watchdog ran under the factory image");
    a_load_err_fallback: assert property (
        s_r.state == ST_LOAD && loadError && !factoryActive && cfgRequestN
            |=> causeCode == CAUSE_LOAD_ERR && s_r.target == 3'h0 && s_r.state == ST_CMD)
        else $error("load error not recorded or no fallback");
    a_app_page_range: assert property (
        userMode && factoryActive && ctrlWrite && ctrlPage != 3'h0
            |=> s_r.appPage == $past(ctrlPage))
        else $error("application page not taken");
    a_crc_error_flag: assert property (
        crcMismatch && s_r.state == ST_USER && cfgRequestN && !wdExpire
            && !(appLoad && factoryActive) |=> crcError)
        else $error("crc mismatch did not raise the error pin");
    a_io_after_init: assert property (
        $rose(ioEnable) |-> $past(s_r.state) == ST_INIT && s_r.state == ST_USER)
        else $error("i/o enabled outside initialisation");
    a_request_reload: assert property (
        !cfgRequestN |=> s_r.state == ST_CMD && !ioEnable && causeCode == CAUSE_EXT_REQ
            ##1 (!ioEnable && !userMode))
        else $error("configuration request did not force command mode");
    a_cause_held: assert property (
        causeCode != CAUSE_NONE && !(statusRead && factoryActive && userMode)
            && cfgRequestN && s_r.state == ST_CMD |=> $stable(causeCode))
        else $error("cause changed before being read");
    a_chain_enable_out: assert property (
        !chainCfgEnableOutN |-> userMode && ioEnable)
        else $error("chain enable output low outside user mode");

    c_wdog_timeout: cover property (wdExpire);
    c_load_fallback: cover property (s_r.state == ST_LOAD && loadError && !factoryActive);
    c_crc_error: cover property ($rose(crcError));
    c_app_load: cover property (userMode && factoryActive && appLoad ##[1:20] loadReq);

endmodule : remote_update_config_control
`default_nettype wire

// ---- hw/rupd_params.svh ----
// Constants for the configuration-loading control block
`ifndef RUPD_PARAMS_SVH
`define RUPD_PARAMS_SVH

`define RUPD_PAGE_W       3
`define RUPD_FACTORY_PAGE 3'h0
`define RUPD_LOCAL_PAGE   3'h1
`define RUPD_MAX_APP_PAGE 3'h7
`define RUPD_WD_W         16
`define RUPD_CLK_NS       25
`define RUPD_WD_TICK_NS   1000
`define RUPD_WD_TICK_CYC  ((`RUPD_WD_TICK_NS + `RUPD_CLK_NS - 1) / `RUPD_CLK_NS)
`define RUPD_CRC_W        32
`define RUPD_CRC_POLY     32'hedb88320
`define RUPD_CRC_INIT     32'hffffffff

`endif

// ---- hw/rupd_pkg.sv ----
// Types for the configuration-loading control block
`default_nettype none
package rupd_pkg;

    typedef enum logic [1:0] {
        ST_CMD  = 2'b00,
        ST_LOAD = 2'b01,
        ST_INIT = 2'b10,
        ST_USER = 2'b11
    } cfgState_t;

    typedef enum logic [1:0] {
        CAUSE_NONE     = 2'b00,
        CAUSE_WDOG     = 2'b01,
        CAUSE_LOAD_ERR = 2'b10,
        CAUSE_EXT_REQ  = 2'b11
    } cause_t;

endpackage : rupd_pkg
`default_nettype wire

// ---- hw/seu_crc_check.sv ----
// CRC-32 scan of configuration memory against a reference value
`timescale 1ns/100ps
`default_nettype none
`include "rupd_params.svh"

module seu_crc_check (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // Scan stream
    input  wire logic                   scanEnable,
    input  wire logic [7:0]             scanWord,
    input  wire logic                   scanValid,
    input  wire logic                   scanLast,
    input  wire logic [`RUPD_CRC_W-1:0] refCrc,
    // Result
    output logic                        mismatch
);

    typedef struct packed {
        logic [`RUPD_CRC_W-1:0] crc;
        logic                   mismatch;
    } crcState_t;

    crcState_t s_r;
    crcState_t s_nxt;

    function automatic logic [`RUPD_CRC_W-1:0] crcByte(input logic [`RUPD_CRC_W-1:0] c,
                                                      input logic [7:0] d);
        logic [`RUPD_CRC_W-1:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `RUPD_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crcByte

    always_comb begin
        logic [`RUPD_CRC_W-1:0] c;
        c = crcByte(s_r.crc, scanWord);
        s_nxt = s_r;
        s_nxt.mismatch = 1'b0;
        if (!scanEnable) begin
            s_nxt.crc = `RUPD_CRC_INIT;
        end else if (scanValid) begin
            if (scanLast) begin
                s_nxt.mismatch = (c != refCrc);
                s_nxt.crc      = `RUPD_CRC_INIT;
            end else begin
                s_nxt.crc = c;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r <= '{crc: `RUPD_CRC_INIT, mismatch: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mismatch = s_r.mismatch;

endmodule : seu_crc_check
`default_nettype wire

// ---- verif/cfg_mem_model.sv ----
// Paged configuration memory answering load requests
`timescale 1ns/100ps
`default_nettype none
`include "rupd_params.svh"

module cfg_mem_model #(
    parameter int DELAY = 5
) (
    // Clock
    input  wire logic                   core_clk,
    // Load request from device
    input  wire logic                   loadReq,
    input  wire logic [`RUPD_PAGE_W-1:0] pageAddr,
    // Page that fails to load, zero for none
    input  wire logic [`RUPD_PAGE_W-1:0] failPage,
    // Load result
    output logic                        loadDone,
    output logic                        loadError
);
    int                      cnt = 0;
    logic [`RUPD_PAGE_W-1:0] pg  = '0;

    // Clocked source, page selected per request
    always @(posedge core_clk) begin
        loadDone  <= 1'b0;
        loadError <= 1'b0;
        if (loadReq) begin
            cnt <= DELAY;
            pg  <= pageAddr;
        end else if (cnt == 1) begin
            cnt <= 0;
            // Factory page is never overwritten, so it always loads
            if (pg == failPage && pg != `RUPD_FACTORY_PAGE) loadError <= 1'b1;
            else loadDone <= 1'b1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule : cfg_mem_model
`default_nettype wire

// ---- verif/remote_update_config_control_test.sv ----
// Testbench for the configuration-loading control block
`timescale 1ns/100ps
`default_nettype none
`include "rupd_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, (a), (b)); end end

module remote_update_config_control_test;
    import rupd_pkg::*;
    logic core_clk, rst, remoteMode, chainCfgEnableInN, chainCfgEnableOutN, cfgRequestN;
    logic [2:0]  pageAddr, failPage, ctrlPage;
    logic        loadReq, loadDone, loadError, ctrlWrite, ctrlWdEnable, appLoad;
    logic        wdClear, statusRead, factoryActive, userMode, ioEnable, crcError;
    logic        scanValid, scanLast;
    logic [15:0] ctrlWdTimeout;
    logic [7:0]  scanWord;
    logic [31:0] refCrc, crc;
    cause_t      causeCode;
    int          errors, checked;

    remote_update_config_control i_dut (.core_clk(core_clk), .rst(rst),
        .remoteMode(remoteMode), .chainCfgEnableInN(chainCfgEnableInN),
        .chainCfgEnableOutN(chainCfgEnableOutN), .cfgRequestN(cfgRequestN),
        .pageAddr(pageAddr), .loadReq(loadReq), .loadDone(loadDone), .loadError(loadError),
        .ctrlWrite(ctrlWrite), .ctrlPage(ctrlPage), .ctrlWdEnable(ctrlWdEnable),
        .ctrlWdTimeout(ctrlWdTimeout), .appLoad(appLoad), .wdClear(wdClear),
        .statusRead(statusRead), .causeCode(causeCode), .factoryActive(factoryActive),
        .userMode(userMode), .ioEnable(ioEnable), .scanWord(scanWord),
        .scanValid(scanValid), .scanLast(scanLast), .refCrc(refCrc), .crcError(crcError));
    cfg_mem_model i_mem (.core_clk(core_clk), .loadReq(loadReq), .pageAddr(pageAddr),
        .failPage(failPage), .loadDone(loadDone), .loadError(loadError));

    always #12.5 core_clk = ~core_clk;

    task conclude;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    task waitLoad(input logic [2:0] pg);
        int i;
        i = 0;
        while (loadReq !== 1'b1 && i < 400) begin @(posedge core_clk); #1; i++; end
        `CHK(loadReq, 1'b1)
        `CHK(pageAddr, pg)
        `CHK(ioEnable, 1'b0)
    endtask : waitLoad

    task waitUser;
        int i;
        i = 0;
        while (userMode !== 1'b1 && i < 400) begin @(posedge core_clk); #1; i++; end
        `CHK({userMode, ioEnable, chainCfgEnableOutN}, 3'b110)
    endtask : waitUser

    task waitCause(input cause_t c);
        int i;
        i = 0;
        while (causeCode !== c && i < 400) begin @(posedge core_clk); #1; i++; end
        `CHK(causeCode, c)
        `CHK(userMode, 1'b0)
    endtask : waitCause

    task ctrlSet(input logic [2:0] pg, input logic go);
        @(negedge core_clk);
        {ctrlPage, ctrlWdEnable, ctrlWdTimeout, ctrlWrite} = {pg, 1'b1, 16'h0002, 1'b1};
        @(negedge core_clk);
        ctrlWrite = 1'b0;
        appLoad   = go;
        @(negedge core_clk);
        appLoad   = 1'b0;
    endtask : ctrlSet

    // Stream four bytes then check the sticky error flag
    task scan(input logic bad, input logic exp);
        crc = `RUPD_CRC_INIT;
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk);
            {scanWord, scanValid, scanLast} = {8'h10 + 8'(i), 1'b1, i == 3};
            crc = crc ^ {24'h0, scanWord};
            for (int k = 0; k < 8; k++) crc = crc[0] ? (crc >> 1) ^ `RUPD_CRC_POLY : crc >> 1;
            refCrc = bad ? ~crc : crc;
        end
        @(negedge core_clk);
        {scanValid, scanLast} = 2'b00;
        repeat (4) @(negedge core_clk);
        `CHK(crcError, exp)
    endtask : scan

    initial begin
        #(25 * 20000);
        errors++;
        conclude();
    end

    initial begin
        {core_clk, rst, remoteMode, cfgRequestN, chainCfgEnableInN} = 5'b01110;
        {failPage, ctrlPage, ctrlWrite, ctrlWdEnable, appLoad} = '0;
        {wdClear, statusRead, scanValid, scanLast, ctrlWdTimeout, scanWord, refCrc} = '0;
        errors = 0;
        checked = 0;
        repeat (20) @(negedge core_clk);
        `CHK({loadReq, causeCode, factoryActive, userMode, ioEnable}, 6'b000100)
        rst = 1'b0;
        waitLoad(`RUPD_FACTORY_PAGE);
        waitUser();
        scan(1'b0, 1'b0);
        scan(1'b1, 1'b1);
        ctrlSet(3'h3, 1'b0);
        repeat (200) @(negedge core_clk);
        `CHK({userMode, causeCode}, 3'b100)
        @(negedge core_clk) appLoad = 1'b1;
        @(negedge core_clk) appLoad = 1'b0;
        waitLoad(3'h3);
        `CHK(factoryActive, 1'b0)
        `CHK(crcError, 1'b0)
        waitUser();
        repeat (6) begin
            repeat (50) @(negedge core_clk);
            wdClear = 1'b1;
            @(negedge core_clk) wdClear = 1'b0;
        end
        // Timeout of two ticks: still running 80 edges after the clear, gone at 81
        repeat (80) @(negedge core_clk);
        `CHK(userMode, 1'b1)
        @(negedge core_clk);
        `CHK(causeCode, CAUSE_WDOG)
        waitCause(CAUSE_WDOG);
        waitLoad(`RUPD_FACTORY_PAGE);
        waitUser();
        `CHK(causeCode, CAUSE_WDOG)
        @(negedge core_clk) statusRead = 1'b1;
        @(negedge core_clk) statusRead = 1'b0;
        @(negedge core_clk);
        `CHK(causeCode, CAUSE_NONE)
        failPage = `RUPD_MAX_APP_PAGE;
        ctrlSet(`RUPD_MAX_APP_PAGE, 1'b1);
        waitLoad(`RUPD_MAX_APP_PAGE);
        waitCause(CAUSE_LOAD_ERR);
        waitLoad(`RUPD_FACTORY_PAGE);
        waitUser();
        @(negedge core_clk) cfgRequestN = 1'b0;
        @(negedge core_clk) cfgRequestN = 1'b1;
        waitCause(CAUSE_EXT_REQ);
        waitLoad(`RUPD_FACTORY_PAGE);
        waitUser();
        // Second reset in local mode with the chain enable held off
        @(negedge core_clk);
        {rst, remoteMode, chainCfgEnableInN} = 3'b101;
        repeat (20) @(negedge core_clk);
        `CHK({loadReq, causeCode, factoryActive, userMode, ioEnable}, 6'b000100)
        `CHK(chainCfgEnableOutN, 1'b1)
        rst = 1'b0;
        repeat (5) @(negedge core_clk);
        `CHK({loadReq, pageAddr, userMode}, 5'b00000)
        chainCfgEnableInN = 1'b0;
        waitLoad(`RUPD_LOCAL_PAGE);
        `CHK(factoryActive, 1'b0)
        waitUser();
        conclude();
    end
endmodule : remote_update_config_control_test
`default_nettype wire
